// ### logic/lcdr_pkg.sv
// Constants, codes and types for the segment LCD RAM driver
// Contract
// - Display RAM spans E0h..F7h, processor read/write
// - Matrix of 45 segments by up to 4 commons
// - Bit one lights element, zero leaves off
// - First three segment positions have no pin
// - Six-byte group per common, first byte hidden
// - Group head bytes are spare data bytes
// - F8h..FEh are plain RAM, never displayed
// - Inactive commons' byte groups are ignored
// - Reset leaves display RAM contents untouched
// - Reset clears mode setting, display off
// - Display off also drops bias network enable
// - In halt, run only from stand-by oscillator
// - Halt without stand-by oscillator switches off
// - Missing clock grounds all segments and commons
// - Mode writes shadowed, applied at frame end
// - Halt with pending change: discard, display off
// - Duty code 00=4, 01=1, 10=2, 11=3
// - Divider code selects off, stand-by, or /32../256
// - Rate code picks 64..512 Hz base drive
// - Low-resistance bias on 8 reference ticks per edge
package lcdr_pkg;

  // Data-space window of the block
  localparam logic [7:0] ADDR_FIRST     = 8'hE0;
  localparam logic [7:0] ADDR_DISP_LAST = 8'hF7;
  localparam logic [7:0] ADDR_LAST      = 8'hFE;
  localparam int         MEM_WORDS      = 31;

  // Matrix shape
  localparam int COMMONS      = 4;
  localparam int SEG_LINES    = 45;  // Pins for segment positions 4..48
  localparam int SEG_UNMAPPED = 5;   // Positions 4..8 own no memory bits
  localparam int GROUP_BYTES  = 6;   // Bytes per common group
  localparam int GROUP_SHOWN  = 5;   // Displayed bytes after the group head
  localparam int SEG_MAPPED   = GROUP_SHOWN * 8;

  // Mode/control field layout
  localparam int         CTRL_RATE_LSB = 0;
  localparam int         CTRL_DIV_LSB  = 3;
  localparam int         CTRL_DUTY_LSB = 6;
  localparam logic [7:0] CTRL_RESET    = 8'h00;

  // Oscillator divider codes
  localparam logic [2:0] DIV_OFF     = 3'h0;
  localparam logic [2:0] DIV_STANDBY = 3'h1;
  localparam logic [2:0] DIV_BAD_LO  = 3'h2;
  localparam logic [2:0] DIV_32      = 3'h3;
  localparam logic [2:0] DIV_256     = 3'h6;
  localparam logic [2:0] DIV_BAD_HI  = 3'h7;
  localparam logic [3:0] DIV_LOG2_OFFSET = 4'h2;  // Code 3 divides by 2^5

  // Duty codes
  localparam logic [1:0] DUTY_FOUR  = 2'h0;
  localparam logic [1:0] LAST_SLOT4 = 2'h3;

  // Base drive rates in Hz for rate codes 0..6; code 7 falls back to code 0
  localparam int         REF_HZ    = 32768;
  localparam int         RATE_HZ [0:6] = '{64, 85, 128, 171, 256, 341, 512};
  localparam logic [2:0] RATE_BAD  = 3'h7;

  // Low-resistance bias window, in reference ticks
  localparam logic [3:0] BOOST_TICKS = 4'h8;

  // Clock supervisor: four reference periods without a tick means missing
  localparam int CLK_PERIOD_NS  = 40;
  localparam int SUP_TIMEOUT_NS = 122070;
  localparam int SUP_CYCLES     = SUP_TIMEOUT_NS / CLK_PERIOD_NS;

  // Display sequencer states
  typedef enum logic [2:0] {
    ST_OFF   = 3'h1,
    ST_RUN   = 3'h2,
    ST_FAULT = 3'h4
  } lcdr_state_t;

  // Reference ticks per half period of the base drive, rounded to nearest
  function automatic logic [8:0] half_period(input logic [2:0] rate);
    int hz;
    hz = (rate == RATE_BAD) ? RATE_HZ[0] : RATE_HZ[rate];
    return 9'((REF_HZ + hz) / (2 * hz));
  endfunction : half_period

endpackage : lcdr_pkg

// ### logic/lcdr_sync.sv
// Two-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module lcdr_sync
  #(parameter int WIDTH = 1)
  (
  // Clock and reset
  input  wire logic             mclk_in,
  input  wire logic             reset_in,
  // Asynchronous side
  input  wire logic [WIDTH-1:0] async_in,
  // Synchronised side
  output logic      [WIDTH-1:0] sync_out
  );

  logic [WIDTH-1:0] stage1;  // Read only by the second stage

  // Elaboration check on the width
  if (WIDTH < 1)
  begin : g_bad_width
    $error("lcdr_sync: WIDTH must be at least 1");
  end

  // Two stages; metastability settles in the first
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      stage1   <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule : lcdr_sync
`default_nettype wire

// ### logic/lcdr_driver.sv
// Segment LCD controller: display RAM, mode shadow, scan and clock supervision
`timescale 1ns/1ps
`default_nettype none
module lcdr_driver
  import lcdr_pkg::*;
  #(parameter int SUP_LIMIT = SUP_CYCLES)
  (
  // Clock and reset
  input  wire logic                 mclk_in,
  input  wire logic                 reset_in,
  // Processor data-space port
  input  wire logic [7:0]           addr_in,
  input  wire logic                 wr_en_in,
  input  wire logic                 rd_en_in,
  input  wire logic [7:0]           wdata_in,
  output logic      [7:0]           rdata_out,
  // Mode/control write from the core
  input  wire logic                 mode_write_in,
  input  wire logic                 duty_select_lo_in,
  input  wire logic                 duty_select_hi_in,
  input  wire logic                 osc_divider_select_b0_in,
  input  wire logic                 osc_divider_select_b1_in,
  input  wire logic                 osc_divider_select_b2_in,
  input  wire logic                 drive_rate_select_b0_in,
  input  wire logic                 drive_rate_select_b1_in,
  input  wire logic                 drive_rate_select_b2_in,
  // Power state
  input  wire logic                 halt_in,
  input  wire logic                 standby_osc_active_in,
  input  wire logic                 standby_osc_in,
  // Panel side
  output logic      [SEG_LINES-1:0] segment_out,
  output logic      [COMMONS-1:0]   common_out,
  output logic                      drive_polarity_out,
  output logic                      bias_enable_out,
  output logic                      bias_boost_out,
  // Status
  output logic                      display_on_out,
  output logic                      clock_missing_out,
  output logic                      mode_pending_out
  );

  // Elaboration checks
  if (SUP_LIMIT < 1 || SUP_LIMIT > 4095)
  begin : g_bad_limit
    $error("lcdr_driver: SUP_LIMIT must be 1..4095");
  end

  // Storage and control state
  logic [7:0]       mem [0:MEM_WORDS-1];  // Display and spare bytes, never reset
  logic [7:0]       shadow_ctrl;          // Last written mode setting
  logic             pending;              // Shadow not yet applied
  logic [7:0]       active_ctrl;          // Setting the scan runs with
  logic             halt_q;               // Halt level, for entry detection
  lcdr_state_t      state;
  lcdr_state_t      next_state;
  // Time base
  logic [7:0]       presc;                // Main clock prescaler
  logic             sb_sync;              // Synchronised stand-by oscillator
  logic             sb_prev;              // For its rising edge
  logic [8:0]       half_cnt;             // Ticks inside a half period
  logic             polarity;             // Second half of the slot
  logic [1:0]       slot;                 // Active common
  logic [3:0]       boost_left;           // Ticks left of low-resistance bias
  logic [11:0]      sup_cnt;              // Cycles since the last tick

  // Decoded fields
  logic [2:0]       div_code;
  logic [2:0]       rate_code;
  logic [1:0]       duty_code;
  logic [1:0]       last_slot;
  logic [8:0]       hp;
  logic [7:0]       div_mask;
  logic             div_main;
  logic             code_ok;
  logic             main_tick;
  logic             ref_tick;
  logic             base_edge;
  logic             slot_step;
  logic             frame_end;
  logic             halt_kill;
  logic             clk_missing;
  logic             mem_hit;
  logic [4:0]       mem_idx;
  logic [SEG_MAPPED-1:0] pattern;
  logic [7:0]       new_ctrl;

  assign new_ctrl  = {duty_select_hi_in, duty_select_lo_in,
                      osc_divider_select_b2_in, osc_divider_select_b1_in,
                      osc_divider_select_b0_in, drive_rate_select_b2_in,
                      drive_rate_select_b1_in, drive_rate_select_b0_in};
  assign div_code  = active_ctrl[CTRL_DIV_LSB +: 3];
  assign rate_code = active_ctrl[CTRL_RATE_LSB +: 3];
  assign duty_code = active_ctrl[CTRL_DUTY_LSB +: 2];
  // Duty 00 scans four commons, otherwise the code counts them
  assign last_slot = (duty_code == DUTY_FOUR) ? LAST_SLOT4 : duty_code - 2'h1;
  assign hp        = half_period(rate_code);
  assign div_main  = (div_code >= DIV_32) && (div_code <= DIV_256);
  // Unused divider codes behave as display off
  assign code_ok   = div_main || (div_code == DIV_STANDBY);
  assign div_mask  = 8'(((9'h1 << ({1'b0, div_code} + DIV_LOG2_OFFSET)) - 9'h1));

  // Processor window: the display RAM plus the spare bytes up to FEh
  assign mem_hit = (addr_in >= ADDR_FIRST) && (addr_in <= ADDR_LAST);
  assign mem_idx = 5'(addr_in - ADDR_FIRST);

  // Stand-by oscillator pin crossing
  lcdr_sync #(.WIDTH(1)) u_sb_sync (
    .mclk_in  (mclk_in),
    .reset_in (reset_in),
    .async_in (standby_osc_in),
    .sync_out (sb_sync)
  );

  // Display RAM: plain byte storage, no reset so contents survive it
  always_ff @(posedge mclk_in)
  begin
    if (wr_en_in && mem_hit)
      mem[mem_idx] <= wdata_in;
  end

  // Read data, zero outside the window
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
      rdata_out <= 8'h00;
    else if (rd_en_in)
      rdata_out <= mem_hit ? mem[mem_idx] : 8'h00;
  end

  // Pattern for the current common; group head byte skipped, LSB is lowest
  always_comb
  begin
    pattern = '0;
    for (int b = 0; b < GROUP_SHOWN; b++)
      pattern[b*8 +: 8] = mem[int'(slot) * GROUP_BYTES + 1 + b];
  end

  // Halt entry: keep running only from a live stand-by source with no change due
  assign halt_kill = halt_in && !halt_q &&
                     (pending || !(div_code == DIV_STANDBY && standby_osc_active_in));

  // Shadow register and pending flag; a new write wins over the clear
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      shadow_ctrl <= CTRL_RESET;
      pending     <= 1'b0;
    end
    else if (mode_write_in)
    begin
      shadow_ctrl <= new_ctrl;
      pending     <= 1'b1;
    end
    else if (halt_kill || frame_end || state == ST_OFF)
      pending     <= 1'b0;
  end

  // Active setting: shadow taken at a frame end or at once while off; halt kill loads the reset value
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
      active_ctrl <= CTRL_RESET;
    else if (halt_kill)
      active_ctrl <= CTRL_RESET;
    else if (pending && (frame_end || state == ST_OFF))
      active_ctrl <= shadow_ctrl;
  end

  // Halt level history
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
      halt_q <= 1'b0;
    else
      halt_q <= halt_in;
  end

  // Main prescaler; free running, its output is gated off in halt
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
      presc <= 8'h00;
    else
      presc <= presc + 8'h01;
  end

  // Stand-by edge history, fed from the second synchroniser stage
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
      sb_prev <= 1'b0;
    else
      sb_prev <= sb_sync;
  end

  // The main oscillator path is absent in halt; stand-by keeps ticking
  assign main_tick = !halt_in && ((presc & div_mask) == div_mask);
  assign ref_tick  = (div_code == DIV_STANDBY) ? (sb_sync && !sb_prev) :
                     (div_main ? main_tick : 1'b0);
  assign base_edge = (state == ST_RUN) && ref_tick && (half_cnt == hp - 9'h1);
  assign slot_step = base_edge && polarity;
  assign frame_end = slot_step && (slot == last_slot);

  // Half-period counter and drive polarity
  always_ff @(posedge mclk_in)
  begin
    if (reset_in || state == ST_OFF)
    begin
      half_cnt <= 9'h000;
      polarity <= 1'b0;
    end
    else if (base_edge)
    begin
      half_cnt <= 9'h000;
      polarity <= !polarity;
    end
    else if (ref_tick)
      half_cnt <= half_cnt + 9'h001;
  end

  // Common slot: walks only the active commons, wraps at frame end
  always_ff @(posedge mclk_in)
  begin
    if (reset_in || state == ST_OFF)
      slot <= 2'h0;
    else if (frame_end)
      slot <= 2'h0;
    else if (slot_step)
      slot <= slot + 2'h1;
  end

  // Low-resistance bias window after each drive edge
  always_ff @(posedge mclk_in)
  begin
    if (reset_in || state == ST_OFF)
      boost_left <= 4'h0;
    else if (base_edge)
      boost_left <= BOOST_TICKS;
    else if (ref_tick && boost_left != 4'h0)
      boost_left <= boost_left - 4'h1;
  end

  // Clock supervisor: counts cycles since the last reference tick
  always_ff @(posedge mclk_in)
  begin
    if (reset_in || state == ST_OFF || ref_tick)
      sup_cnt <= 12'h000;
    else if (!clk_missing)
      sup_cnt <= sup_cnt + 12'h001;
  end
  assign clk_missing = (sup_cnt == 12'(SUP_LIMIT));

  // Sequencer: off, scanning, or grounded for a missing clock
  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_OFF:   if (code_ok) next_state = ST_RUN;
      ST_RUN:   if (!code_ok) next_state = ST_OFF;
                else if (clk_missing) next_state = ST_FAULT;
      ST_FAULT: if (!code_ok) next_state = ST_OFF;
                else if (ref_tick) next_state = ST_RUN;
      default:  next_state = ST_OFF;
    endcase
  end

  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
      state <= ST_OFF;
    else
      state <= next_state;
  end

  // Panel drive, registered; everything grounded unless scanning
  always_ff @(posedge mclk_in)
  begin
    if (reset_in || state != ST_RUN)
    begin
      segment_out        <= '0;
      common_out         <= '0;
      drive_polarity_out <= 1'b0;
      bias_enable_out    <= 1'b0;
      bias_boost_out     <= 1'b0;
    end
    else
    begin
      // Positions 4..8 have no memory bits and stay dark
      segment_out        <= {pattern, {SEG_UNMAPPED{1'b0}}};
      common_out         <= COMMONS'(1) << slot;
      drive_polarity_out <= polarity;
      bias_enable_out    <= 1'b1;
      bias_boost_out     <= (boost_left != 4'h0);
    end
  end

  // Status flags
  assign display_on_out    = (state == ST_RUN);
  assign clock_missing_out = (state == ST_FAULT);
  assign mode_pending_out  = pending;

  // Helper: reference ticks seen while the boost window is open
  logic [4:0] boost_seen;
  always_ff @(posedge mclk_in)
  begin
    if (reset_in || boost_left == 4'h0)
      boost_seen <= 5'h00;
    else if (ref_tick)
      boost_seen <= boost_seen + 5'h01;
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);

  reset_clears_a: assert property (disable iff (1'b0)
    reset_in |=> state == ST_OFF && active_ctrl == CTRL_RESET && !pending)
    else $error("reset did not clear the mode setting");
  off_ground_a: assert property (state != ST_RUN |=>
    segment_out == '0 && common_out == '0 && !bias_enable_out && !bias_boost_out)
    else $error("outputs driven while display is off");
  missing_clock_a: assert property (
    state == ST_RUN && code_ok && clk_missing |=> state == ST_FAULT ##1 common_out == '0)
    else $error("missing clock did not ground the panel");
  shadow_hold_a: assert property (
    pending && !frame_end && state != ST_OFF && !halt_kill |=> $stable(active_ctrl))
    else $error("mode changed away from a frame end");
  halt_discard_a: assert property (
    halt_kill && !mode_write_in |=> !pending ##1 state == ST_OFF)
    else $error("halt left a pending change or display on");
  boost_len_a: assert property (
    base_edge |=> boost_left == BOOST_TICKS ##0 boost_seen <= 5'(BOOST_TICKS))
    else $error("bias boost window wrong length");
  common_range_a: assert property (
    common_out != '0 |-> $onehot(common_out) && $past(slot) <= $past(last_slot))
    else $error("inactive common driven");
  ram_readback_a: assert property (
    (wr_en_in && mem_hit) ##1 (rd_en_in && !wr_en_in && addr_in == $past(addr_in))
    |=> rdata_out == $past(wdata_in, 2))
    else $error("display RAM readback mismatch");
  boost_cap_a: assert property (boost_seen <= 5'(BOOST_TICKS))
    else $error("bias boost exceeded its window");

  run_c:   cover property (state == ST_OFF ##1 state == ST_RUN);
  frame_c: cover property (frame_end && pending);
  fault_c: cover property (state == ST_FAULT);
  halt_c:  cover property (halt_kill);

endmodule : lcdr_driver
`default_nettype wire

// ### tb/lcdr_panel_model.sv
// Passive multiplexed segment panel: records what each common line showed
`timescale 1ns/1ps
`default_nettype none
module lcdr_panel_model
  import lcdr_pkg::*;
  (
  // Clock and capture control
  input  wire logic                 clk_in,
  input  wire logic                 clear_in,
  // Drive from the controller
  input  wire logic [SEG_LINES-1:0] segment_in,
  input  wire logic [COMMONS-1:0]   common_in,
  input  wire logic                 boost_in,
  // Observations
  output logic      [SEG_LINES-1:0] lit_out [COMMONS],
  output logic      [COMMONS-1:0]   used_out,
  output logic      [15:0]          boost_len_out
  );
  logic [15:0] boost_run;  // Cycles the low-resistance divider has been on

  // Latch the segment pattern of whichever single common is driven
  always_ff @(posedge clk_in)
  begin
    if (clear_in)
      used_out <= '0;  // Forget commons seen earlier
    else
      used_out <= used_out | common_in;
    for (int k = 0; k < COMMONS; k++)
      if (common_in == COMMONS'(1 << k))
        lit_out[k] <= segment_in;  // Glass only sees one backplane at a time
  end

  // Width of each boost pulse; kept as the last completed run length
  always_ff @(posedge clk_in)
  begin
    boost_run <= boost_in ? boost_run + 16'h0001 : 16'h0000;
    if (!boost_in && boost_run != 16'h0000)
      boost_len_out <= boost_run;
  end
endmodule : lcdr_panel_model
`default_nettype wire

// ### tb/tb_lcdr_driver.sv
// Self-checking bench for the segment LCD RAM driver
`timescale 1ns/1ps
`default_nettype none
module tb_lcdr_driver;
  import lcdr_pkg::*;
  localparam int SUP = 64;  // Short supervisor window keeps the run brief

  // Design stimulus and response
  logic                 mclk_in  = 1'b0;
  logic                 reset_in = 1'b1;
  logic [7:0]           addr_in  = 8'h00;
  logic                 wr_en_in = 1'b0;
  logic                 rd_en_in = 1'b0;
  logic [7:0]           wdata_in = 8'h00;
  logic [7:0]           rdata_out;
  logic                 mode_write_in = 1'b0;
  logic [7:0]           sel      = 8'h00;  // {duty hi,lo, divider b2..b0, rate b2..b0}
  logic                 halt_in  = 1'b0;
  logic                 sb_act   = 1'b0;
  logic                 sb_osc   = 1'b0;
  logic                 sb_run   = 1'b0;
  logic [SEG_LINES-1:0] segment_out;
  logic [COMMONS-1:0]   common_out;
  logic                 bias_en, boost, disp_on, clk_miss, pend;
  logic                 clear_in = 1'b1;
  logic [SEG_LINES-1:0] lit [COMMONS];
  logic [COMMONS-1:0]   used;
  logic [15:0]          boost_len;
  int                   n_fail, tests_run, cyc, w, sb_cnt;
  logic                 pol, p0;  // Drive polarity now and one half period earlier
  logic [1:0]           duty_tab [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
  logic [3:0]           mask_tab [4] = '{4'h1, 4'h3, 4'h7, 4'hF};

  lcdr_driver #(.SUP_LIMIT(SUP)) i_dut (.mclk_in(mclk_in), .reset_in(reset_in),
    .addr_in(addr_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .wdata_in(wdata_in),
    .rdata_out(rdata_out), .mode_write_in(mode_write_in),
    .duty_select_hi_in(sel[7]), .duty_select_lo_in(sel[6]),
    .osc_divider_select_b2_in(sel[5]), .osc_divider_select_b1_in(sel[4]),
    .osc_divider_select_b0_in(sel[3]), .drive_rate_select_b2_in(sel[2]),
    .drive_rate_select_b1_in(sel[1]), .drive_rate_select_b0_in(sel[0]),
    .halt_in(halt_in), .standby_osc_active_in(sb_act), .standby_osc_in(sb_osc),
    .segment_out(segment_out), .common_out(common_out), .drive_polarity_out(pol),
    .bias_enable_out(bias_en), .bias_boost_out(boost), .display_on_out(disp_on),
    .clock_missing_out(clk_miss), .mode_pending_out(pend));

  lcdr_panel_model i_panel (.clk_in(mclk_in), .clear_in(clear_in),
    .segment_in(segment_out), .common_in(common_out), .boost_in(boost),
    .lit_out(lit), .used_out(used), .boost_len_out(boost_len));

  // 25 MHz main clock
  always #20 mclk_in = ~mclk_in;

  // Stand-by oscillator stand-in: 20 mclk period, stops dead when not running
  always @(negedge mclk_in)
    if (sb_run)
    begin
      sb_cnt = sb_cnt + 1;
      if (sb_cnt == 10)
      begin
        sb_cnt = 0;
        sb_osc = ~sb_osc;
      end
    end

  // Hang guard: full run needs well under this many cycles
  always @(posedge mclk_in)
  begin
    cyc = cyc + 1;
    if (cyc == 95000)
    begin
      n_fail = n_fail + 1;
      end_of_test();
    end
  end

  // Byte pattern for group k, byte j
  function automatic logic [7:0] pat(input int k, input int j);
    return 8'((k * 8'h30) ^ (j * 8'h1B) ^ 8'h5A);
  endfunction : pat

  // Expected segment pins: positions 4..8 low, then bytes +1..+5 LSB first
  function automatic logic [44:0] seg_exp(input int k);
    return {pat(k, 5), pat(k, 4), pat(k, 3), pat(k, 2), pat(k, 1), 5'h00};
  endfunction : seg_exp

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    tests_run = tests_run + 1;
    if (got !== exp)
    begin
      n_fail = n_fail + 1;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  // Reset held for eight cycles, inputs move on falling edges only
  task automatic do_reset();
    reset_in = 1'b1;
    repeat (8) @(negedge mclk_in);
    reset_in = 1'b0;
    @(negedge mclk_in);
  endtask : do_reset

  // One-cycle write strobe, then an idle cycle so strobes never merge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr_in  = a;
    wdata_in = d;
    wr_en_in = 1'b1;
    @(negedge mclk_in);
    wr_en_in = 1'b0;
    @(negedge mclk_in);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    addr_in  = a;
    rd_en_in = 1'b1;
    @(negedge mclk_in);
    rd_en_in = 1'b0;
    @(negedge mclk_in);
    chk("rdata", {56'h0, exp}, {56'h0, rdata_out});
  endtask : rd

  task automatic mode(input logic [1:0] d, input logic [2:0] v, input logic [2:0] r);
    sel           = {d, v, r};
    mode_write_in = 1'b1;
    @(negedge mclk_in);
    mode_write_in = 1'b0;
  endtask : mode

  task automatic end_of_test();
    $display("Comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_of_test

  // Main sequence
  initial
  begin
    do_reset();
    chk("display_on", 0, disp_on);
    chk("bias_enable", 0, bias_en);
    chk("panel", 0, {common_out, segment_out});
    for (int a = 8'hE0; a <= 8'hFE; a++)
      wr(8'(a), 8'(a) ^ 8'h3C);
    for (int a = 8'hE0; a <= 8'hFE; a++)
      rd(8'(a), 8'(a) ^ 8'h3C);
    rd(8'h10, 8'h00);
    // Write then read the same spare byte back to back
    addr_in  = 8'hF8;
    wdata_in = 8'hA5;
    wr_en_in = 1'b1;
    @(negedge mclk_in);
    wr_en_in = 1'b0;
    rd_en_in = 1'b1;
    @(negedge mclk_in);
    rd_en_in = 1'b0;
    @(negedge mclk_in);
    chk("rdata_b2b", 64'h00A5, {56'h0, rdata_out});
    for (int k = 0; k < COMMONS; k++)
      for (int j = 1; j <= GROUP_SHOWN; j++)
        wr(8'(ADDR_FIRST + GROUP_BYTES * k + j), pat(k, j));
    // Every duty code, main clock /32, 512 Hz; later changes wait for frame end
    for (int i = 0; i < 4; i++)
    begin
      mode(duty_tab[i], 3'h3, 3'h6);
      if (i > 0)
        chk("pending", 1, pend);
      for (w = 0; w < 10000 && pend !== 1'b0; w++) @(negedge mclk_in);
      repeat (4) @(negedge mclk_in);
      chk("display_on", 1, disp_on);
      chk("bias_enable", 1, bias_en);
      // 512 Hz: a half period is 32 reference ticks of 32 clocks, one flip per window
      p0 = pol;
      repeat (1024) @(negedge mclk_in);
      chk("polarity", {63'h0, !p0}, {63'h0, pol});
      clear_in = 1'b1;
      @(negedge mclk_in);
      clear_in = 1'b0;
      repeat ((i + 1) * 2048 + 300) @(negedge mclk_in);
      chk("commons", mask_tab[i], used);
      for (int k = 0; k <= i; k++)
        chk("segments", seg_exp(k), lit[k]);
    end
    chk("boost_len", 16'h0100, boost_len);
    // Stand-by source: allow a whole frame before halting
    sb_act = 1'b1;
    sb_run = 1'b1;
    mode(2'h0, 3'h1, 3'h6);
    repeat (16000) @(negedge mclk_in);
    halt_in = 1'b1;
    repeat (200) @(negedge mclk_in);
    chk("display_on", 1, disp_on);
    sb_run = 1'b0;
    for (w = 0; w < 300 && clk_miss !== 1'b1; w++) @(negedge mclk_in);
    repeat (3) @(negedge mclk_in);
    chk("clock_missing", 1, clk_miss);
    chk("panel", 0, {common_out, segment_out});
    sb_run = 1'b1;
    for (w = 0; w < 100 && clk_miss !== 1'b0; w++) @(negedge mclk_in);
    chk("clock_missing", 0, clk_miss);
    halt_in = 1'b0;
    // Halt with the stand-by oscillator inactive turns the display off
    sb_act = 1'b0;
    @(negedge mclk_in);
    halt_in = 1'b1;
    repeat (4) @(negedge mclk_in);
    chk("display_on", 0, disp_on);
    chk("bias_enable", 0, bias_en);
    halt_in = 1'b0;
    // Unused divider codes must leave the display dark
    mode(2'h0, 3'h2, 3'h6);
    repeat (4) @(negedge mclk_in);
    chk("display_on", 0, disp_on);
    mode(2'h0, 3'h7, 3'h6);
    repeat (4) @(negedge mclk_in);
    chk("display_on", 0, disp_on);
    // Halt while a change is still pending discards it
    sb_act = 1'b1;
    mode(2'h0, 3'h1, 3'h6);
    for (w = 0; w < 10 && disp_on !== 1'b1; w++) @(negedge mclk_in);
    mode(2'h1, 3'h1, 3'h6);
    halt_in = 1'b1;
    repeat (4) @(negedge mclk_in);
    chk("display_on", 0, disp_on);
    chk("pending", 0, pend);
    halt_in = 1'b0;
    // Second reset mid-run: display off, memory untouched
    mode(2'h0, 3'h3, 3'h6);
    repeat (5) @(negedge mclk_in);
    do_reset();
    chk("display_on", 0, disp_on);
    chk("bias_enable", 0, bias_en);
    rd(8'hE0, 8'hE0 ^ 8'h3C);
    rd(8'hE1, pat(0, 1));
    end_of_test();
  end
endmodule : tb_lcdr_driver
`default_nettype wire
